// ---- hdl/tecc_config.sv ----
// Purpose: Configuration register, lock bits and event pin of a thermal sensor
// Assumes: Serial bus decoding is done outside; one-cycle read and write strobes
// Notes: Lock bits are cleared only by RST_B_I, standing in for power-on reset
// Contract
// - Critical lock blocks critical threshold writes
// - Window lock blocks upper and lower writes
// - Locks reset zero, stick, only reset clears
// - One write with a one sets lock
// - Clear bit drops latched event, interrupt mode only
// - Clear bit write-only, reads zero
// - Status bit shows pin asserted, read-only
// - Output enable gates the event pin
// - Critical-only limits event to critical condition
// - Either lock freezes enable, critical-only, polarity, mode
// - Polarity bit selects active low or high
// - Mode bit selects comparator or interrupt
// - Window status bits set and clear with hysteresis
// - Critical status sets rising, clears minus hysteresis
// - Hysteresis field selects none, 1.5, 3, 6 degrees
`timescale 1ns/1ps
module tecc_config #(
  parameter int TEMP_W = 13
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic [TEMP_W-1:0] TEMP_I,
  input wire logic TEMP_VALID_I,
  output logic EVENT_O,
  output logic [2:0] TRIP_STATUS_O
);
  if (TEMP_W != 13) begin : g_chk
    $error("TEMP_W must be 13 to match the threshold layout");
  end

  typedef struct packed {
    logic crit_lock;
    logic win_lock;
    logic oe;
    logic crit_only;
    logic pol;
    logic mode;
    logic [1:0] hys_sel;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] crit;
    logic latch;
    logic cond_prev;
    logic [15:0] rdata;
    logic pin;
  } tecc_cfg_s;

  tecc_cfg_s st_q;
  tecc_cfg_s st_d;

  tecc_trip_if #(.TEMP_W(TEMP_W)) tif ();

  // Address match shared by the write and read paths
  function automatic logic tecc_hit(input logic [7:0] a, input logic [7:0] off);
    tecc_hit = (a == off);
  endfunction

  logic any_lock;
  logic cond;
  logic active;
  logic asserted;
  logic wr_cfg;
  logic clr_evt;

  // Event condition and pin level derive from registered state
  assign any_lock = st_q.crit_lock | st_q.win_lock;
  assign cond = st_q.crit_only ? tif.status[tecc_pkg::TRIP_CRIT] : |tif.status;
  assign active = st_q.mode ? st_q.latch : cond;
  assign asserted = st_q.oe & active;
  assign wr_cfg = REG_WR_I & tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_CONFIG);
  assign clr_evt = wr_cfg & REG_WDATA_I[tecc_pkg::BIT_CLEAR] & st_q.mode;

  // Next-state logic for registers, event latch and pin
  always_comb begin
    st_d = st_q;
    st_d.cond_prev = cond;
    // New event wins over a clear arriving in the same cycle
    if (clr_evt) begin
      st_d.latch = 1'b0;
    end
    if (cond & ~st_q.cond_prev) begin
      st_d.latch = 1'b1;
    end
    if (wr_cfg) begin
      // Locks only ever go to one here
      st_d.crit_lock = st_q.crit_lock | REG_WDATA_I[tecc_pkg::BIT_CRIT_LOCK];
      st_d.win_lock = st_q.win_lock | REG_WDATA_I[tecc_pkg::BIT_WIN_LOCK];
      // Lock state before this write decides, so a locking write still lands its fields
      if (!any_lock) begin
        st_d.oe = REG_WDATA_I[tecc_pkg::BIT_OE];
        st_d.crit_only = REG_WDATA_I[tecc_pkg::BIT_CRIT_ONLY];
        st_d.pol = REG_WDATA_I[tecc_pkg::BIT_POL];
        st_d.mode = REG_WDATA_I[tecc_pkg::BIT_MODE];
        st_d.hys_sel = REG_WDATA_I[tecc_pkg::BIT_HYS_HI:tecc_pkg::BIT_HYS_LO];
      end
    end
    if (REG_WR_I && tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_CRIT) && !st_q.crit_lock) begin
      st_d.crit = REG_WDATA_I & tecc_pkg::THR_MASK;
    end
    if (REG_WR_I && tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_UPPER) && !st_q.win_lock) begin
      st_d.upper = REG_WDATA_I & tecc_pkg::THR_MASK;
    end
    if (REG_WR_I && tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_LOWER) && !st_q.win_lock) begin
      st_d.lower = REG_WDATA_I & tecc_pkg::THR_MASK;
    end
    // Read data is captured on the strobe; unmapped offsets read zero
    if (REG_RD_I) begin
      st_d.rdata = 16'h0000;
      if (tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_CONFIG)) begin
        st_d.rdata[tecc_pkg::BIT_CRIT_LOCK] = st_q.crit_lock;
        st_d.rdata[tecc_pkg::BIT_WIN_LOCK] = st_q.win_lock;
        st_d.rdata[tecc_pkg::BIT_CLEAR] = 1'b0;
        st_d.rdata[tecc_pkg::BIT_STATUS] = asserted;
        st_d.rdata[tecc_pkg::BIT_OE] = st_q.oe;
        st_d.rdata[tecc_pkg::BIT_CRIT_ONLY] = st_q.crit_only;
        st_d.rdata[tecc_pkg::BIT_POL] = st_q.pol;
        st_d.rdata[tecc_pkg::BIT_MODE] = st_q.mode;
        st_d.rdata[tecc_pkg::BIT_HYS_HI:tecc_pkg::BIT_HYS_LO] = st_q.hys_sel;
      end else if (tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_UPPER)) begin
        st_d.rdata = st_q.upper;
      end else if (tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_LOWER)) begin
        st_d.rdata = st_q.lower;
      end else if (tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_CRIT)) begin
        st_d.rdata = st_q.crit;
      end
    end
    // Asserted level follows polarity; disabled output rests inactive
    st_d.pin = st_q.pol ? asserted : ~asserted;
  end

  // State register; reset is the only path that clears the locks
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_q <= '0;
      st_q.hys_sel <= tecc_pkg::HYS_RESET;
      st_q.upper <= tecc_pkg::THR_RESET;
      st_q.lower <= tecc_pkg::THR_RESET;
      st_q.crit <= tecc_pkg::THR_RESET;
      st_q.pin <= 1'b1; // Inactive level for the reset polarity
    end else begin
      st_q <= st_d;
    end
  end

  // Comparator side
  assign tif.temp = TEMP_I;
  assign tif.temp_valid = TEMP_VALID_I;
  assign tif.upper = st_q.upper;
  assign tif.lower = st_q.lower;
  assign tif.crit = st_q.crit;
  assign tif.hys_sel = st_q.hys_sel;

  tecc_trip #(.TEMP_W(TEMP_W)) u_trip (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .tif(tif.trip)
  );

  assign REG_RDATA_O = st_q.rdata;
  assign EVENT_O = st_q.pin;
  assign TRIP_STATUS_O = tif.status;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  property p_crit_lock_wr;
    REG_WR_I && tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_CRIT) && st_q.crit_lock |=> $stable(st_q.crit);
  endproperty
  a_crit_lock_wr: assert property (p_crit_lock_wr) else $error("critical threshold changed under lock");

  property p_win_lock_wr;
    REG_WR_I && st_q.win_lock && (tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_UPPER) ||
      tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_LOWER)) |=> $stable(st_q.upper) && $stable(st_q.lower);
  endproperty
  a_win_lock_wr: assert property (p_win_lock_wr) else $error("window threshold changed under lock");

  property p_lock_sticky;
    st_q.crit_lock || st_q.win_lock |=> $past(st_q.crit_lock) <= st_q.crit_lock && $past(st_q.win_lock) <= st_q.win_lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared without reset");

  property p_lock_single;
    wr_cfg && REG_WDATA_I[tecc_pkg::BIT_CRIT_LOCK] && REG_WDATA_I[tecc_pkg::BIT_WIN_LOCK]
      |=> st_q.crit_lock && st_q.win_lock;
  endproperty
  a_lock_single: assert property (p_lock_single) else $error("single write did not set locks");

  property p_clear_evt;
    clr_evt && !(cond && !st_q.cond_prev) |=> !st_q.latch;
  endproperty
  a_clear_evt: assert property (p_clear_evt) else $error("event clear did not drop latch");

  property p_read_cfg;
    REG_RD_I && tecc_hit(REG_ADDR_I, tecc_pkg::ADDR_CONFIG)
      |=> !REG_RDATA_O[tecc_pkg::BIT_CLEAR] && REG_RDATA_O[tecc_pkg::BIT_STATUS] == $past(asserted);
  endproperty
  a_read_cfg: assert property (p_read_cfg) else $error("config readback of clear or status wrong");

  property p_locked_fields;
    wr_cfg && any_lock |=> $stable({st_q.oe, st_q.crit_only, st_q.pol, st_q.mode, st_q.hys_sel});
  endproperty
  a_locked_fields: assert property (p_locked_fields) else $error("event field changed under lock");

  property p_pin_disabled;
    !st_q.oe ##1 1'b1 |-> EVENT_O == !$past(st_q.pol);
  endproperty
  a_pin_disabled: assert property (p_pin_disabled) else $error("disabled pin not at inactive level");

  property p_pin_level;
    st_q.oe && !st_q.mode && !st_q.crit_only ##1 1'b1 |-> EVENT_O == ($past(st_q.pol) ~^ $past(|tif.status));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("comparator pin level wrong");

  // Checked at the pin, so a window trip leaking through would show
  property p_crit_only;
    st_q.oe && st_q.crit_only && !st_q.mode ##1 1'b1
      |-> EVENT_O == ($past(st_q.pol) ~^ $past(tif.status[tecc_pkg::TRIP_CRIT]));
  endproperty
  a_crit_only: assert property (p_crit_only) else $error("critical-only event on window condition");

  c_lock_set: cover property (wr_cfg && REG_WDATA_I[tecc_pkg::BIT_WIN_LOCK] ##1 st_q.win_lock);
  c_int_clear: cover property (st_q.mode && st_q.latch ##1 clr_evt ##1 !st_q.latch);
  c_pin_active: cover property (asserted ##1 EVENT_O == st_q.pol);
endmodule

// ---- hdl/tecc_pkg.sv ----
// Purpose: Shared constants for the thermal event configuration block
// Assumes: Temperatures in two's complement, LSB 0.0625 degC, 13 bits wide
// Notes: Hysteresis amounts are given in temperature LSBs
package tecc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_UPPER = 8'h02;
  localparam logic [7:0] ADDR_LOWER = 8'h03;
  localparam logic [7:0] ADDR_CRIT = 8'h04;
  // Configuration bit positions
  localparam int BIT_MODE = 0;
  localparam int BIT_POL = 1;
  localparam int BIT_CRIT_ONLY = 2;
  localparam int BIT_OE = 3;
  localparam int BIT_STATUS = 4;
  localparam int BIT_CLEAR = 5;
  localparam int BIT_WIN_LOCK = 6;
  localparam int BIT_CRIT_LOCK = 7;
  localparam int BIT_HYS_LO = 9;
  localparam int BIT_HYS_HI = 10;
  // Trip status positions inside the three-bit status vector
  localparam int TRIP_BELOW = 0;
  localparam int TRIP_ABOVE = 1;
  localparam int TRIP_CRIT = 2;
  localparam int TRIP_N = 3;
  // Threshold registers keep bits 12:2 only
  localparam logic [15:0] THR_MASK = 16'h1ffc;
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [1:0] HYS_RESET = 2'h0;
  // Hysteresis selections and their sizes in 0.0625 degC steps
  localparam logic [1:0] HYS_NONE = 2'h0;
  localparam logic [1:0] HYS_1P5 = 2'h1;
  localparam logic [1:0] HYS_3P0 = 2'h2;
  localparam logic [13:0] HYS_AMT_1P5 = 14'h0018;
  localparam logic [13:0] HYS_AMT_3P0 = 14'h0030;
  localparam logic [13:0] HYS_AMT_6P0 = 14'h0060;
endpackage

// ---- hdl/tecc_trip.sv ----
// Purpose: Below-window, above-window and above-critical status with hysteresis
// Assumes: Temperature sample is taken when temp_valid is high
// Notes: Between set and clear points a status bit holds its value
`timescale 1ns/1ps
module tecc_trip #(
  parameter int TEMP_W = 13
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  tecc_trip_if.trip tif
);
  typedef struct packed {
    logic [tecc_pkg::TRIP_N-1:0] status;
  } tecc_trip_s;

  tecc_trip_s st_q;
  tecc_trip_s st_d;

  // Sign extend to 14 bits so subtracting hysteresis cannot wrap
  function automatic logic signed [13:0] tecc_sext(input logic [15:0] v);
    tecc_sext = {v[12], v[12:0]};
  endfunction

  // Hysteresis size from the two-bit select
  function automatic logic signed [13:0] tecc_hys(input logic [1:0] sel);
    case (sel)
      tecc_pkg::HYS_NONE: tecc_hys = 14'h0000;
      tecc_pkg::HYS_1P5: tecc_hys = tecc_pkg::HYS_AMT_1P5;
      tecc_pkg::HYS_3P0: tecc_hys = tecc_pkg::HYS_AMT_3P0;
      default: tecc_hys = tecc_pkg::HYS_AMT_6P0;
    endcase
  endfunction

  logic signed [13:0] t_s;
  logic signed [13:0] h_s;
  logic signed [13:0] thr_s [tecc_pkg::TRIP_N];

  assign t_s = tecc_sext(16'(tif.temp));
  assign h_s = tecc_hys(tif.hys_sel);
  assign thr_s[tecc_pkg::TRIP_BELOW] = tecc_sext(tif.lower & tecc_pkg::THR_MASK);
  assign thr_s[tecc_pkg::TRIP_ABOVE] = tecc_sext(tif.upper & tecc_pkg::THR_MASK);
  assign thr_s[tecc_pkg::TRIP_CRIT] = tecc_sext(tif.crit & tecc_pkg::THR_MASK);

  // Each channel has a set point and a clear point; below-window is mirrored
  always_comb begin
    st_d = st_q;
    if (tif.temp_valid) begin
      for (int i = 0; i < tecc_pkg::TRIP_N; i++) begin
        if (i == tecc_pkg::TRIP_BELOW) begin
          if (t_s >= thr_s[i]) begin
            st_d.status[i] = 1'b0;
          end else if (t_s <= thr_s[i] - h_s) begin
            st_d.status[i] = 1'b1;
          end
        end else begin
          if (t_s > thr_s[i]) begin
            st_d.status[i] = 1'b1;
          end else if (t_s <= thr_s[i] - h_s) begin
            st_d.status[i] = 1'b0;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tif.status = st_q.status;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_crit_set;
    tif.temp_valid && (t_s > thr_s[tecc_pkg::TRIP_CRIT]) |=> tif.status[tecc_pkg::TRIP_CRIT];
  endproperty
  a_crit_set: assert property (p_crit_set) else $error("critical status not set above threshold");

  property p_below_clear;
    tif.temp_valid && (t_s >= thr_s[tecc_pkg::TRIP_BELOW]) |=> !tif.status[tecc_pkg::TRIP_BELOW];
  endproperty
  a_below_clear: assert property (p_below_clear) else $error("below status not cleared");

  property p_above_hold;
    tif.temp_valid && (t_s <= thr_s[tecc_pkg::TRIP_ABOVE]) && (t_s > thr_s[tecc_pkg::TRIP_ABOVE] - h_s)
      |=> $stable(tif.status[tecc_pkg::TRIP_ABOVE]);
  endproperty
  a_above_hold: assert property (p_above_hold) else $error("above status moved inside hysteresis band");
endmodule

// ---- hdl/tecc_trip_if.sv ----
// Purpose: Carries thresholds and temperature to the trip comparator
// Assumes: One clock domain
// Notes: The status vector comes back from the comparator
`timescale 1ns/1ps
interface tecc_trip_if #(parameter int TEMP_W = 13);
  logic [TEMP_W-1:0] temp;
  logic temp_valid;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [15:0] crit;
  logic [1:0] hys_sel;
  logic [tecc_pkg::TRIP_N-1:0] status;
  modport cfg (output temp, temp_valid, upper, lower, crit, hys_sel, input status);
  modport trip (input temp, temp_valid, upper, lower, crit, hys_sel, output status);
endinterface

// ---- verif/tecc_host_model.sv ----
// Purpose: Host side of the register strobes, one word per access
// Assumes: Strobes change just after a rising clock edge
// Notes: Address and data show inverted junk once released
`timescale 1ns/1ps
module tecc_host_model (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end

  // One-cycle write strobe; junk afterwards so stale data is never reused
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  // Read data lands one cycle after the taken strobe
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the configuration, lock and event logic
// Assumes: Thresholds lower 0x0100, upper 0x0400, critical 0x0500 to start
// Notes: Trip status is predicted by a reference function, never read back
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic rst_b;
  logic [12:0] temp;
  logic temp_vld;
  logic wr, rd;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, rv;
  logic event_pin;
  logic [2:0] trip;
  logic [2:0] exp_st;
  logic [15:0] lo, up, cr;
  integer miscompares, n_checks, seed, i, k;

  tecc_config tecc_config_inst (.CLK_I(clk), .RST_B_I(rst_b), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .TEMP_I(temp),
    .TEMP_VALID_I(temp_vld), .EVENT_O(event_pin), .TRIP_STATUS_O(trip));
  tecc_host_model tecc_host_model_inst (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reference trip status: above and critical set above threshold, clear at threshold minus hysteresis; below is mirrored
  function automatic logic [2:0] trip_next(input logic [2:0] st, input logic [12:0] t, input logic [1:0] hs);
    int tv, h, l, u, c;
    logic [2:0] n;
    tv = int'(signed'(t));
    h = (hs == 2'h0) ? 0 : (hs == 2'h1) ? 24 : (hs == 2'h2) ? 48 : 96;
    l = int'(signed'(lo[12:0]));
    u = int'(signed'(up[12:0]));
    c = int'(signed'(cr[12:0]));
    n = st;
    if (tv > c) n[2] = 1'b1;
    else if (tv <= c - h) n[2] = 1'b0;
    if (tv > u) n[1] = 1'b1;
    else if (tv <= u - h) n[1] = 1'b0;
    if (tv >= l) n[0] = 1'b0;
    else if (tv <= l - h) n[0] = 1'b1;
    return n;
  endfunction

  // One sample; status is looked at just after the edge that takes the sample
  task automatic sample(input logic [12:0] t, input logic [1:0] hs);
    @(posedge clk);
    temp <= t;
    temp_vld <= 1'b1;
    @(posedge clk);
    temp_vld <= 1'b0;
    temp <= ~t;
    exp_st = trip_next(exp_st, t, hs);
    #1;
    chk("trip_status", {13'h0000, trip}, {13'h0000, exp_st});
  endtask

  initial begin
    miscompares = 0;
    n_checks = 0;
    seed = 32'h848e60cb;
    rst_b = 1'b0;
    temp = 13'h0000;
    temp_vld = 1'b0;
    exp_st = 3'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // Reset state: everything zero, pin inactive for active-low default
    tecc_host_model_inst.rd_reg(8'h01, rv);
    chk("config_reset", rv, 16'h0000);
    chk("event_reset", {15'h0000, event_pin}, 16'h0001);
    lo = 16'h0100;
    up = 16'h0400;
    cr = 16'h0500;
    tecc_host_model_inst.wr_reg(8'h02, up);
    tecc_host_model_inst.wr_reg(8'h03, lo);
    tecc_host_model_inst.wr_reg(8'h04, cr | 16'he003);
    tecc_host_model_inst.rd_reg(8'h04, rv);
    chk("crit_thr", rv, cr);
    // Status and clear bits cannot be written and read zero
    tecc_host_model_inst.wr_reg(8'h01, 16'h0038);
    tecc_host_model_inst.rd_reg(8'h01, rv);
    chk("config_ro_wo", rv, 16'h0008);
    // Every hysteresis, critical-only, polarity and enable mix, random temperatures
    for (i = 0; i < 32; i++) begin
      tecc_host_model_inst.wr_reg(8'h01, {5'h00, i[1:0], 5'h00, i[4], i[2], i[3], 1'b0});
      for (k = 0; k < 8; k++) begin
        sample(13'h0080 + (13'($random(seed)) & 13'h07ff), i[1:0]);
        @(posedge clk);
        #1;
        chk("event_cmp", {15'h0000, event_pin},
          {15'h0000, i[4] ? (i[3] ~^ (i[2] ? exp_st[2] : |exp_st)) : ~i[3]});
      end
    end
    sample(13'h0200, 2'h3);
    // Interrupt mode: latch holds after the condition goes, clear drops it
    tecc_host_model_inst.wr_reg(8'h01, 16'h000b);
    sample(13'h0450, 2'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("event_latched", {15'h0000, event_pin}, 16'h0001);
    tecc_host_model_inst.rd_reg(8'h01, rv);
    chk("event_status", rv, 16'h001b);
    sample(13'h0200, 2'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("event_held", {15'h0000, event_pin}, 16'h0001);
    tecc_host_model_inst.wr_reg(8'h01, 16'h002b);
    repeat (2) @(posedge clk);
    #1;
    chk("event_cleared", {15'h0000, event_pin}, 16'h0000);
    // Comparator mode: clear request has no effect
    tecc_host_model_inst.wr_reg(8'h01, 16'h000a);
    sample(13'h0450, 2'h0);
    tecc_host_model_inst.wr_reg(8'h01, 16'h002a);
    repeat (2) @(posedge clk);
    #1;
    chk("cmp_no_clear", {15'h0000, event_pin}, 16'h0001);
    // Latch kept across the mode switch shows the comparator-mode clear did nothing
    tecc_host_model_inst.wr_reg(8'h01, 16'h000b);
    repeat (2) @(posedge clk);
    #1;
    chk("cmp_clear_kept", {15'h0000, event_pin}, 16'h0001);
    sample(13'h0200, 2'h0);
    // Window lock set alone on purpose, against the usual host practice
    tecc_host_model_inst.wr_reg(8'h01, 16'h0049);
    tecc_host_model_inst.wr_reg(8'h02, 16'h0200);
    tecc_host_model_inst.rd_reg(8'h02, rv);
    chk("upper_locked", rv, up);
    tecc_host_model_inst.wr_reg(8'h03, 16'h0040);
    tecc_host_model_inst.rd_reg(8'h03, rv);
    chk("lower_locked", rv, lo);
    tecc_host_model_inst.wr_reg(8'h04, 16'h0300);
    tecc_host_model_inst.rd_reg(8'h04, rv);
    chk("crit_open", rv, 16'h0300);
    tecc_host_model_inst.wr_reg(8'h01, 16'h0606);
    tecc_host_model_inst.rd_reg(8'h01, rv);
    chk("config_frozen", rv & 16'hffef, 16'h0049);
    tecc_host_model_inst.wr_reg(8'h01, 16'h0080);
    tecc_host_model_inst.wr_reg(8'h04, 16'h0600);
    tecc_host_model_inst.rd_reg(8'h04, rv);
    chk("crit_locked", rv, 16'h0300);
    tecc_host_model_inst.rd_reg(8'h01, rv);
    chk("both_locks", rv & 16'hffef, 16'h00c9);
    // Only reset frees the locks
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    tecc_host_model_inst.rd_reg(8'h01, rv);
    chk("locks_reset", rv, 16'h0000);
    wrap_up();
  end

  // Watchdog well past the expected run of about 900 cycles
  initial begin
    #1000000;
    miscompares = miscompares + 1;
    wrap_up();
  end
endmodule
